/* verilog/lcdi_top.sv */
// ----------------------------------------
// Character display instruction decoder
// ----------------------------------------
module lcdi_top
   import lcdi_pkg::*;
(
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic register_select_i,
   input wire logic read_write_i,
   input wire logic enable_i,
   input wire logic [7:0] data_i,
   output logic [7:0] data_o,
   output logic data_oe_n_o,
   output logic busy_flag_o,
   output logic [6:0] address_counter_o,
   output logic glyph_select_o,
   output logic increment_o,
   output logic display_shift_enable_o,
   output logic display_enable_o,
   output logic cursor_enable_o,
   output logic cursor_blink_o,
   output logic bus_width_select_o,
   output logic two_line_o,
   output logic tall_font_o,
   output logic [6:0] display_offset_o
);
   import lcdi_pkg::*;

   // ----------------------------------------
   // Decode helper
   // ----------------------------------------
   // Highest set bit names the instruction
   function automatic lcdi_op_t decode_instr(input logic [7:0] code);
      lcdi_op_t op;
      op = OP_NONE;
      if (code[B_DDADDR]) begin
         op = OP_DDADDR;
      end else if (code[B_CGADDR]) begin
         op = OP_CGADDR;
      end else if (code[B_FUNC]) begin
         op = OP_FUNC;
      end else if (code[B_SHIFT]) begin
         op = OP_SHIFT;
      end else if (code[B_DISP]) begin
         op = OP_DISP;
      end else if (code[B_ENTRY]) begin
         op = OP_ENTRY;
      end else if (code[B_HOME]) begin
         op = OP_HOME;
      end else if (code[B_CLEAR]) begin
         op = OP_CLEAR;
      end
      return op;
   endfunction

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_meta;   // First stage
   logic rst_n;      // Released reset for the design

   // Assert at once, release after two edges
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [10:0] pin_meta;   // First stage, read only by second
   logic [10:0] pin_sync;   // Stable copies
   logic en_prev;           // Enable, one cycle late
   wire rs_s = pin_sync[10];
   wire rw_s = pin_sync[9];
   wire en_s = pin_sync[8];
   wire [7:0] db_s = pin_sync[7:0];
   wire en_rise = en_s && !en_prev;
   wire en_fall = !en_s && en_prev;

   // Two flops on every host pin
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta <= '0;
         pin_sync <= '0;
         en_prev <= 1'b0;
      end else begin
         pin_meta <= {register_select_i, read_write_i, enable_i, data_i};
         pin_sync <= pin_meta;
         en_prev <= en_s;
      end
   end

   // ----------------------------------------
   // Internal oscillator enable
   // ----------------------------------------
   logic [5:0] osc_cnt;   // Divider count
   logic osc_tick;        // One-cycle pulse at oscillator rate

   // Divide the system clock down to the oscillator rate
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         osc_cnt <= '0;
         osc_tick <= 1'b0;
      end else begin
         osc_tick <= (osc_cnt == OSC_DIV - 6'h01);
         osc_cnt <= (osc_cnt == OSC_DIV - 6'h01) ? 6'h00 : osc_cnt + 6'h01;
      end
   end

   // ----------------------------------------
   // Host transfer assembly
   // ----------------------------------------
   logic nib_phase;        // Low nibble expected next
   logic [3:0] nib_high;   // Stored upper nibble
   logic [7:0] instruction_holding_reg;
   logic [7:0] data_holding_reg;
   logic [7:0] read_snap;  // Byte being returned
   logic pending_instr;    // Latched, not yet run
   logic pending_data;     // Latched RAM write waiting
   logic pending_read;     // Latched RAM read waiting
   lcdi_state_t state;
   lcdi_state_t next_state;
   lcdi_ram_if ram_bus ();

   wire idle = (state == ST_IDLE);
   wire byte_done = bus_width_select_o || nib_phase;
   wire [7:0] whole_byte = bus_width_select_o ? db_s : {nib_high, db_s[7:4]};
   wire [7:0] status_byte = {busy_flag_o, address_counter_o};
   wire [7:0] read_byte = rs_s ? ram_bus.rd_data : status_byte;
   wire take_write = en_fall && !rw_s && byte_done && idle;
   wire take_read = en_fall && rw_s && rs_s && byte_done && idle;

   // Nibble pairing, upper half first on the upper lines
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         nib_phase <= 1'b0;
         nib_high <= '0;
      end else if (en_fall && !bus_width_select_o) begin
         nib_phase <= !nib_phase;
         nib_high <= db_s[7:4];
      end else if (bus_width_select_o) begin
         nib_phase <= 1'b0;
      end
   end

   // Read drive: value chosen at enable rise, released at fall
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         data_o <= '0;
         data_oe_n_o <= 1'b1;
         read_snap <= '0;
      end else if (en_rise && rw_s) begin
         data_oe_n_o <= 1'b0;
         if (bus_width_select_o) begin
            data_o <= read_byte;
         end else if (!nib_phase) begin
            read_snap <= read_byte;
            data_o <= {read_byte[7:4], 4'h0};
         end else begin
            data_o <= {read_snap[3:0], 4'h0};
         end
      end else if (en_fall) begin
         data_oe_n_o <= 1'b1;
      end
   end

   // Holding registers; transfers while busy are dropped
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         instruction_holding_reg <= '0;
         data_holding_reg <= '0;
         pending_instr <= 1'b0;
         pending_data <= 1'b0;
         pending_read <= 1'b0;
      end else if (take_write || take_read) begin
         instruction_holding_reg <= rs_s ? instruction_holding_reg : whole_byte;
         data_holding_reg <= rs_s ? whole_byte : data_holding_reg;
         pending_instr <= !rs_s;
         pending_data <= rs_s && !rw_s;
         pending_read <= take_read;
      end
   end

   // ----------------------------------------
   // Execution sequencer
   // ----------------------------------------
   logic [8:0] wait_ticks;    // Oscillator ticks left
   logic [6:0] fill_addr;     // Clear fill pointer
   lcdi_op_t op;
   wire started = take_write || take_read;
   wire [6:0] ac_step = increment_o ? address_counter_o + 7'h01
                                    : address_counter_o - 7'h01;
   wire [6:0] ac_next = glyph_select_o ? (ac_step & GLYPH_MASK) : ac_step;
   // Cursor shift keeps a glyph address inside its six bits
   wire [6:0] shift_step = instruction_holding_reg[B_RL] ? address_counter_o + 7'h01 : address_counter_o - 7'h01;
   wire [6:0] shift_next = glyph_select_o ? (shift_step & GLYPH_MASK) : shift_step;

   always_comb begin
      if (pending_data) begin
         op = OP_WRITE;
      end else if (pending_read) begin
         op = OP_READ;
      end else begin
         op = decode_instr(instruction_holding_reg);
      end
   end

   // Next state: wait for a tick, fill on clear, time the rest
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: if (started) next_state = ST_PEND;
         ST_PEND: if (osc_tick) next_state = (op == OP_CLEAR) ? ST_FILL : ST_WAIT;
         ST_FILL: if (fill_addr == LAST_ADDR) next_state = ST_WAIT;
         ST_WAIT: if (osc_tick && wait_ticks <= 9'h001) next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   // State and busy flag; busy rises with the accepting edge
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         busy_flag_o <= 1'b0;
      end else begin
         state <= next_state;
         busy_flag_o <= (next_state != ST_IDLE);
      end
   end

   // Execution time counter in oscillator ticks
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         wait_ticks <= '0;
      end else if (state == ST_PEND && osc_tick) begin
         case (op)
            OP_CLEAR, OP_HOME: wait_ticks <= CLEAR_TICKS;
            OP_WRITE, OP_READ: wait_ticks <= DATA_TICKS;
            default: wait_ticks <= SHORT_TICKS;
         endcase
      end else if (state == ST_WAIT && osc_tick && wait_ticks != 9'h000) begin
         wait_ticks <= wait_ticks - 9'h001;
      end
   end

   // Clear fill pointer walks all display RAM
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         fill_addr <= '0;
      end else if (state == ST_FILL) begin
         fill_addr <= fill_addr + 7'h01;
      end else begin
         fill_addr <= HOME_ADDR;
      end
   end

   // ----------------------------------------
   // RAM port
   // ----------------------------------------
   wire exec = (state == ST_PEND) && osc_tick;
   assign ram_bus.wr_en = (state == ST_FILL) || (exec && op == OP_WRITE);
   assign ram_bus.glyph_sel = (state == ST_FILL) ? 1'b0 : glyph_select_o;
   assign ram_bus.addr = (state == ST_FILL) ? fill_addr : address_counter_o;
   assign ram_bus.wr_data = (state == ST_FILL) ? SPACE_CODE : data_holding_reg;

   lcdi_ram u_ram (
      .clock_i(clock_i),
      .ram(ram_bus.mem)
   );

   // ----------------------------------------
   // Address counter and modes
   // ----------------------------------------
   // Instruction effects, applied on the executing tick
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         address_counter_o <= HOME_ADDR;
         glyph_select_o <= 1'b0;
         increment_o <= 1'b1;
         display_shift_enable_o <= 1'b0;
         display_offset_o <= '0;
      end else if (exec) begin
         case (op)
            OP_CLEAR: begin
               address_counter_o <= HOME_ADDR;
               glyph_select_o <= 1'b0;
               increment_o <= 1'b1;
               display_offset_o <= '0;
            end
            OP_HOME: begin
               address_counter_o <= HOME_ADDR;
               glyph_select_o <= 1'b0;
               display_offset_o <= '0;
            end
            OP_ENTRY: begin
               increment_o <= instruction_holding_reg[B_ID];
               display_shift_enable_o <= instruction_holding_reg[B_SH];
            end
            OP_SHIFT: begin
               if (!instruction_holding_reg[B_SC]) begin
                  address_counter_o <= shift_next;
               end else if (instruction_holding_reg[B_RL]) begin
                  display_offset_o <= display_offset_o - 7'h01;
               end else begin
                  display_offset_o <= display_offset_o + 7'h01;
               end
            end
            OP_CGADDR: begin
               address_counter_o <= instruction_holding_reg[6:0] & GLYPH_MASK;
               glyph_select_o <= 1'b1;
            end
            OP_DDADDR: begin
               address_counter_o <= instruction_holding_reg[6:0];
               glyph_select_o <= 1'b0;
            end
            OP_WRITE: begin
               address_counter_o <= ac_next;
               if (display_shift_enable_o && !glyph_select_o) begin
                  display_offset_o <= increment_o ? display_offset_o + 7'h01
                                                  : display_offset_o - 7'h01;
               end
            end
            OP_READ: begin
               address_counter_o <= ac_next;
            end
            default: begin
               address_counter_o <= address_counter_o;
            end
         endcase
      end
   end

   // Display and function flags
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         display_enable_o <= 1'b0;
         cursor_enable_o <= 1'b0;
         cursor_blink_o <= 1'b0;
         bus_width_select_o <= 1'b1;
         two_line_o <= 1'b0;
         tall_font_o <= 1'b0;
      end else if (exec && op == OP_DISP) begin
         display_enable_o <= instruction_holding_reg[B_DON];
         cursor_enable_o <= instruction_holding_reg[B_CON];
         cursor_blink_o <= instruction_holding_reg[B_BON];
      end else if (exec && op == OP_FUNC) begin
         bus_width_select_o <= instruction_holding_reg[B_WIDTH];
         two_line_o <= instruction_holding_reg[B_LINES];
         tall_font_o <= instruction_holding_reg[B_FONT];
      end
   end

endmodule

/* verilog/lcdi_pkg.sv */
package lcdi_pkg;

   // ----------------------------------------
   // Clock and oscillator timing
   // ----------------------------------------
   localparam longint unsigned CLK_HZ = 10_000_000;   // System clock rate
   localparam longint unsigned OSC_HZ = 270_000;      // Internal oscillator rate
   localparam longint unsigned NS_PER_S = 1_000_000_000;
   localparam logic [5:0] OSC_DIV = 6'(CLK_HZ / OSC_HZ); // Clocks per oscillator tick
   localparam longint unsigned CLEAR_NS = 1_530_000;  // Clear and home time, ns
   localparam longint unsigned SHORT_NS = 39_000;     // Most instructions, ns
   localparam longint unsigned DATA_NS = 43_000;      // RAM data access, ns
   // Least times round up to whole oscillator ticks
   localparam logic [8:0] CLEAR_TICKS = 9'((CLEAR_NS * OSC_HZ + NS_PER_S - 1) / NS_PER_S);
   localparam logic [8:0] SHORT_TICKS = 9'((SHORT_NS * OSC_HZ + NS_PER_S - 1) / NS_PER_S);
   localparam logic [8:0] DATA_TICKS = 9'((DATA_NS * OSC_HZ + NS_PER_S - 1) / NS_PER_S);

   // ----------------------------------------
   // Memory geometry and fill value
   // ----------------------------------------
   localparam int DISP_DEPTH = 128;                   // Display RAM words
   localparam int GLYPH_DEPTH = 64;                   // Glyph RAM words
   localparam logic [7:0] SPACE_CODE = 8'h20;         // Clear fill character
   localparam logic [6:0] HOME_ADDR = 7'h00;          // Home address
   localparam logic [6:0] LAST_ADDR = 7'h7f;          // Last display address
   localparam logic [6:0] GLYPH_MASK = 7'h3f;         // Glyph address bits

   // ----------------------------------------
   // Instruction bit positions
   // ----------------------------------------
   localparam int B_DDADDR = 7;    // Display address load marker
   localparam int B_CGADDR = 6;    // Glyph address load marker
   localparam int B_FUNC = 5;      // Function set marker
   localparam int B_SHIFT = 4;     // Cursor or display shift marker
   localparam int B_DISP = 3;      // Display control marker
   localparam int B_ENTRY = 2;     // Entry mode marker
   localparam int B_HOME = 1;      // Return home marker
   localparam int B_CLEAR = 0;     // Clear marker
   localparam int B_WIDTH = 4;     // Function set: bus width
   localparam int B_LINES = 3;     // Function set: line count
   localparam int B_FONT = 2;      // Function set: font height
   localparam int B_SC = 3;        // Shift: display not cursor
   localparam int B_RL = 2;        // Shift: right
   localparam int B_DON = 2;       // Display control: display
   localparam int B_CON = 1;       // Display control: cursor
   localparam int B_BON = 0;       // Display control: blink
   localparam int B_ID = 1;        // Entry mode: increment
   localparam int B_SH = 0;        // Entry mode: shift enable
   localparam int B_BUSY = 7;      // Status read: busy flag

   // Decoded instruction classes
   typedef enum logic [3:0] {
      OP_NONE, OP_CLEAR, OP_HOME, OP_ENTRY, OP_DISP,
      OP_SHIFT, OP_FUNC, OP_CGADDR, OP_DDADDR, OP_WRITE, OP_READ
   } lcdi_op_t;

   // Sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_PEND = 4'b0010,
      ST_FILL = 4'b0100,
      ST_WAIT = 4'b1000
   } lcdi_state_t;

endpackage

/* verilog/lcdi_ram_if.sv */
// ----------------------------------------
// Carrier between sequencer and RAM block
// ----------------------------------------
interface lcdi_ram_if;
   logic wr_en;          // Write strobe, one cycle per data write, held through the clear fill
   logic glyph_sel;      // Target glyph RAM, not display RAM
   logic [6:0] addr;     // Word address
   logic [7:0] wr_data;  // Write data
   logic [7:0] rd_data;  // Registered read data at addr
   modport ctrl (output wr_en, output glyph_sel, output addr, output wr_data, input rd_data);
   modport mem (input wr_en, input glyph_sel, input addr, input wr_data, output rd_data);
endinterface

/* verilog/lcdi_ram.sv */
// ----------------------------------------
// Display and glyph storage
// ----------------------------------------
module lcdi_ram
   import lcdi_pkg::*;
(
   input wire logic clock_i,
   lcdi_ram_if.mem ram
);
   logic [7:0] disp_mem [DISP_DEPTH];   // Display character codes
   logic [7:0] glyph_mem [GLYPH_DEPTH]; // Glyph patterns

   // Write port, no reset: contents are undefined until written or, for display RAM, cleared
   always_ff @(posedge clock_i) begin
      if (ram.wr_en && ram.glyph_sel) begin
         glyph_mem[ram.addr[5:0]] <= ram.wr_data;
      end
      if (ram.wr_en && !ram.glyph_sel) begin
         disp_mem[ram.addr] <= ram.wr_data;
      end
   end

   // Read port, always follows the address one cycle later
   always_ff @(posedge clock_i) begin
      if (ram.glyph_sel) begin
         ram.rd_data <= glyph_mem[ram.addr[5:0]];
      end else begin
         ram.rd_data <= disp_mem[ram.addr];
      end
   end
endmodule

/* testbench/lcdi_monitor.sv */
// ------------------------------
// Port-level checks on the decoder
// ------------------------------
module lcdi_monitor
   import lcdi_pkg::*;
(
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic read_write_i,
   input wire logic enable_i,
   input wire logic data_oe_n_o,
   input wire logic busy_flag_o,
   input wire logic [6:0] address_counter_o,
   input wire logic glyph_select_o,
   input wire logic increment_o,
   input wire logic display_enable_o,
   input wire logic cursor_blink_o,
   input wire logic bus_width_select_o,
   input wire logic two_line_o,
   input wire logic tall_font_o,
   input wire logic [6:0] display_offset_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] busy_cnt; // Cycles busy has stood, clear is the longest
   // Busy length counter
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         busy_cnt <= 16'h0000;
      end else begin
         busy_cnt <= busy_flag_o ? busy_cnt + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   AST_BUSY_START: assert property ($fell(enable_i) && !read_write_i && !busy_flag_o && bus_width_select_o
      |-> ##[3:5] busy_flag_o) else $error("write not accepted");
   AST_BUSY_MIN: assert property ($rose(busy_flag_o) |-> busy_flag_o [*8]) else $error("busy too short");
   AST_BUSY_MAX: assert property (busy_cnt < 16'h3e80) else $error("busy too long");
   AST_OE_READ: assert property ($rose(enable_i) && read_write_i |-> ##[3:4] !data_oe_n_o)
      else $error("read data not driven");
   AST_OE_WRITE: assert property (!read_write_i [*4] |-> data_oe_n_o) else $error("bus driven on write");
   AST_AC_IDLE: assert property (!busy_flag_o && !$past(busy_flag_o) |-> $stable(address_counter_o))
      else $error("address moved while idle");
   AST_CTRL_IDLE: assert property (!busy_flag_o && !$past(busy_flag_o)
      |-> $stable({increment_o, display_enable_o, cursor_blink_o})) else $error("control moved while idle");
   AST_FUNC_IDLE: assert property (!busy_flag_o && !$past(busy_flag_o)
      |-> $stable({bus_width_select_o, two_line_o, tall_font_o})) else $error("function bits moved while idle");
   AST_OFS_IDLE: assert property (!busy_flag_o |=> busy_flag_o || $stable(display_offset_o))
      else $error("display moved while idle");
   AST_GLYPH_AC: assert property (glyph_select_o |-> !address_counter_o[6]) else $error("glyph address wide");
endmodule
bind lcdi_top lcdi_monitor i_mon (.clock_i(clock_i), .arst_n_i(arst_n_i), .read_write_i(read_write_i),
   .enable_i(enable_i), .data_oe_n_o(data_oe_n_o), .busy_flag_o(busy_flag_o),
   .address_counter_o(address_counter_o), .glyph_select_o(glyph_select_o), .increment_o(increment_o),
   .display_enable_o(display_enable_o), .cursor_blink_o(cursor_blink_o),
   .bus_width_select_o(bus_width_select_o), .two_line_o(two_line_o), .tall_font_o(tall_font_o),
   .display_offset_o(display_offset_o));

/* testbench/lcdi_host_model.sv */
// ------------------------------
// Host processor on the parallel port
// ------------------------------
module lcdi_host_model (
   input wire logic clock_i,
   output logic register_select_o,
   output logic read_write_o,
   output logic enable_o,
   output logic [7:0] data_o,
   output logic sample_o
);
   timeunit 1ns;
   timeprecision 1ns;
   bit wide = 1'b1; // Eight-bit bus in use, set by the bench
   // Idle port at time zero
   initial begin
      register_select_o = 1'b0;
      read_write_o = 1'b0;
      enable_o = 1'b0;
      data_o = 8'h00;
      sample_o = 1'b0;
   end
   // One strobe; lines released on reads show a changing pattern
   task automatic xfer(input logic r, input logic w, input logic [7:0] d, input logic chk);
      @(posedge clock_i);
      register_select_o <= r;
      read_write_o <= w;
      data_o <= w ? ~data_o : d;
      @(posedge clock_i);
      enable_o <= 1'b1;
      repeat (5) @(posedge clock_i);
      sample_o <= chk;
      @(posedge clock_i);
      sample_o <= 1'b0;
      enable_o <= 1'b0;
      repeat (6) @(posedge clock_i);
   endtask
   // Whole byte, split upper nibble first on a narrow bus
   task automatic put(input logic r, input logic w, input logic [7:0] d, input logic chk);
      if (wide) begin
         xfer(r, w, d, chk);
      end else begin
         xfer(r, w, {d[7:4], 4'h0}, chk);
         xfer(r, w, {d[3:0], 4'h0}, 1'b0);
      end
   endtask
endmodule

/* testbench/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import lcdi_pkg::*;
   logic clock_i, arst_n_i, rs, rw, en, smp, oe_n, busy, glyph, inc, shen, den, cen, cbl, w8, two, tall;
   logic [7:0] dbus, data_o, rnd;
   logic [6:0] ac, ofs;
   int err_count, cmp_count, cyc;
   logic [7:0] notes[$]; // Expected read data, oldest first
   lcdi_host_model i_host (.clock_i(clock_i), .register_select_o(rs), .read_write_o(rw), .enable_o(en),
      .data_o(dbus), .sample_o(smp));
   lcdi_top i_dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .register_select_i(rs), .read_write_i(rw),
      .enable_i(en), .data_i(dbus), .data_o(data_o), .data_oe_n_o(oe_n), .busy_flag_o(busy),
      .address_counter_o(ac), .glyph_select_o(glyph), .increment_o(inc), .display_shift_enable_o(shen),
      .display_enable_o(den), .cursor_enable_o(cen), .cursor_blink_o(cbl), .bus_width_select_o(w8),
      .two_line_o(two), .tall_font_o(tall), .display_offset_o(ofs));
   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("mismatches %0d compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Wait for busy low, then the half-tick margin
   task automatic idle();
      repeat (5) @(posedge clock_i);
      while (busy !== 1'b0) @(posedge clock_i);
      repeat (20) @(posedge clock_i);
   endtask
   task automatic ins(input logic [7:0] d);
      i_host.put(1'b0, 1'b0, d, 1'b0);
      idle();
   endtask
   task automatic dat(input logic [7:0] d);
      i_host.put(1'b1, 1'b0, d, 1'b0);
      idle();
   endtask
   task automatic rd(input logic r, input logic [7:0] e);
      notes.push_back(e);
      i_host.put(r, 1'b1, 8'h00, 1'b1);
      idle();
   endtask
   // Read watcher takes the oldest note
   always @(posedge clock_i) begin
      if (smp === 1'b1) begin
         if (notes.size() == 0) chk("unexpected read", 8'h00, 8'hff);
         else chk("data_o", notes.pop_front(), data_o);
      end
   end
   // Hang guard, about a third above the expected run
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         finish_test();
      end
   end
   initial begin
      arst_n_i = 1'b0;
      void'($urandom(32'h2672823d));
      rnd = 8'($urandom);
      repeat (4) @(posedge clock_i);
      arst_n_i <= 1'b1;
      repeat (5) @(posedge clock_i);
      chk("reset", 8'he0, {oe_n, inc, w8, den, cen, cbl, two, tall});
      i_host.put(1'b0, 1'b0, 8'h38, 1'b0);
      rd(1'b0, 8'h80);
      chk("func", 8'h06, {5'h0, w8, two, tall});
      rd(1'b0, 8'h00);
      ins(8'h0f);
      chk("ctrl", 8'h07, {5'h0, den, cen, cbl});
      ins(8'h0a);
      chk("ctrl", 8'h02, {5'h0, den, cen, cbl});
      ins(8'h06);
      chk("entry", 8'h02, {6'h0, inc, shen});
      ins(8'h85);
      chk("ac", 8'h05, {1'b0, ac});
      dat(8'h41);
      chk("ac", 8'h06, {1'b0, ac});
      ins(8'h04);
      dat(8'h42);
      chk("ac", 8'h05, {1'b0, ac});
      chk("ofs", 8'h00, {1'b0, ofs});
      ins(8'h85);
      rd(1'b1, 8'h41);
      chk("ac", 8'h04, {1'b0, ac});
      ins(8'h14);
      chk("ac", 8'h05, {1'b0, ac});
      ins(8'h10);
      chk("ac", 8'h04, {1'b0, ac});
      ins(8'h18);
      chk("ofs", 8'h01, {1'b0, ofs});
      ins(8'h1c);
      chk("ofs", 8'h00, {1'b0, ofs});
      ins(8'h07);
      dat(8'h43);
      chk("ofs", 8'h01, {1'b0, ofs});
      ins(8'h02);
      chk("home", 8'h00, {ofs[3:0], ac[3:0]});
      ins(8'h7f);
      chk("glyph", 8'hbf, {glyph, ac});
      dat(8'h11);
      chk("glyph", 8'h80, {glyph, ac});
      ins(8'h7f);
      rd(1'b1, 8'h11);
      ins(8'h90);
      dat(rnd);
      ins(8'h90);
      rd(1'b1, rnd);
      ins(8'h04);
      ins(8'h01);
      chk("clear", 8'h80, {inc, ac});
      rd(1'b1, 8'h20);
      ins(8'h90);
      rd(1'b1, 8'h20);
      ins(8'h2c);
      chk("func", 8'h03, {5'h0, w8, two, tall});
      i_host.wide = 1'b0;
      ins(8'h83);
      chk("ac", 8'h03, {1'b0, ac});
      ins(8'h30);
      chk("width", 8'h01, {7'h0, w8});
      finish_test();
   end
endmodule
